//--- hdl/mbpwm_top.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module mbpwm_top (
	// clock and reset
	input  wire logic                            clk_sys_in,
	input  wire logic                            rst_in,
	// register port
	input  wire logic [mbpwm_pkg::ADDR_W-1:0]    addr_in,
	input  wire logic [mbpwm_pkg::DATA_W-1:0]    wdata_in,
	input  wire logic                            wr_in,
	input  wire logic                            rd_in,
	output logic      [mbpwm_pkg::DATA_W-1:0]    rdata_out,
	// capture pins used as count clock
	input  wire logic [mbpwm_pkg::NUM_CAP-1:0]   capture_in,
	// pulse outputs and interrupt
	output logic      [mbpwm_pkg::NUM_OUT-1:0]   pwm_out,
	output logic                                 irq_out
);
	import mbpwm_pkg::*;

	typedef struct packed {
		logic                              cnt_en;
		logic                              cnt_rst;
		logic                              pwm_en;
		mbpwm_mode_e                       mode;
		logic                              cap_sel;
		logic                              cap_prev;
		logic [DATA_W-1:0]                 tc;
		logic [DATA_W-1:0]                 pc;
		logic [DATA_W-1:0]                 pr;
		logic [MCR_W-1:0]                  mcr;
		logic [NUM_OUT-1:0]                dbl;
		logic [NUM_OUT-1:0]                oen;
		logic [NUM_MATCH-1:0]              ler;
		logic [NUM_MATCH-1:0]              ir;
		logic [NUM_MATCH-1:0]              ien;
		logic [NUM_MATCH-1:0][DATA_W-1:0]  shadow;
		logic [NUM_MATCH-1:0][DATA_W-1:0]  act;
		logic [DATA_W-1:0]                 rdata;
		logic                              irq;
	} mbpwm_top_s;

	mbpwm_top_s           s_q;
	mbpwm_top_s           s_d;
	logic [NUM_CAP-1:0]   cap_lvl;
	logic                 cap_now;
	logic                 evt;
	logic                 wrap;
	logic                 tick;
	logic [NUM_MATCH-1:0] hit;
	logic [NUM_MATCH-1:0] rst_req;
	logic [NUM_MATCH-1:0] stop_req;
	logic [NUM_MATCH-1:0] int_req;
	logic                 hit_rst;
	logic                 hit_stop;
	logic                 xfer;
	logic [NUM_OUT-1:0]   fall_zero;
	logic [NUM_MATCH-1:0] clr_mask;
	logic [3:0]           wslot;
	logic [3:0]           rslot;

	// which match register a byte address selects, or none
	function automatic logic [3:0] match_slot(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] rel;
		rel = a - OFS_MATCH_BASE;
		if (a >= OFS_MATCH_BASE && rel[1:0] == 2'h0 && rel[ADDR_W-1:2] < 6'(NUM_MATCH)) begin
			return {1'b0, rel[4:2]};
		end
		return NO_SLOT;
	endfunction

	// capture pins are asynchronous
	mbpwm_sync u_sync (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.pin_in     (capture_in),
		.lvl_out    (cap_lvl)
	);

	// count event: every clock, or a chosen edge of a capture pin
	always_comb begin
		cap_now = s_q.cap_sel ? cap_lvl[1] : cap_lvl[0];
		unique case (s_q.mode)
			MODE_TIMER: evt = 1'b1;
			MODE_RISE:  evt = cap_now & ~s_q.cap_prev;
			MODE_FALL:  evt = ~cap_now & s_q.cap_prev;
			MODE_BOTH:  evt = cap_now ^ s_q.cap_prev;
		endcase
		wrap = s_q.cnt_en & ~s_q.cnt_rst & evt & (s_q.pc == s_q.pr);
		tick = wrap;
	end

	// match compare and the actions each register asks for
	for (genvar i = 0; i < NUM_MATCH; i++) begin : g_match
		assign hit[i]      = tick & (s_q.tc == s_q.act[i]);
		assign int_req[i]  = hit[i] & s_q.mcr[i*MCR_STRIDE+MCR_INT];
		assign rst_req[i]  = hit[i] & s_q.mcr[i*MCR_STRIDE+MCR_RST];
		assign stop_req[i] = hit[i] & s_q.mcr[i*MCR_STRIDE+MCR_STOP];
	end

	// a match value of zero holds a single-edge output low
	for (genvar j = 0; j < NUM_OUT; j++) begin : g_fz
		assign fall_zero[j] = (s_q.act[j+1] == RST_WORD);
	end

	assign xfer     = s_q.pwm_en & hit[0];
	assign hit_rst  = (|rst_req) | xfer;
	assign hit_stop = |stop_req;
	assign clr_mask = (wr_in && addr_in == OFS_IRQ_CLR) ? wdata_in[NUM_MATCH-1:0] : '0;
	assign wslot    = match_slot(addr_in);
	assign rslot    = match_slot(addr_in);

	// next state of the whole unit
	always_comb begin
		s_d          = s_q;
		s_d.rdata    = RST_WORD;
		s_d.cap_prev = cap_now;
		// prescaler then counter
		if (s_q.cnt_rst) begin
			s_d.tc = RST_WORD;
			s_d.pc = RST_WORD;
		end else if (s_q.cnt_en && evt) begin
			if (wrap) begin
				s_d.pc = RST_WORD;
				s_d.tc = hit_rst ? RST_WORD : s_q.tc + 32'h1;
			end else begin
				s_d.pc = s_q.pc + 32'h1;
			end
		end
		if (hit_stop) begin
			s_d.cnt_en = 1'b0;
		end
		// released values become active as the new cycle starts
		if (xfer) begin
			for (int k = 0; k < NUM_MATCH; k++) begin
				if (s_q.ler[k]) begin
					s_d.act[k] = s_q.shadow[k];
				end
			end
			s_d.ler = '0;
		end
		// register writes
		if (wr_in) begin
			case (addr_in)
				OFS_CTRL: begin
					s_d.cnt_en  = wdata_in[CTRL_CNT_EN];
					s_d.cnt_rst = wdata_in[CTRL_CNT_RST];
					s_d.pwm_en  = wdata_in[CTRL_PWM_EN];
					s_d.mode    = mbpwm_mode_e'(wdata_in[CTRL_MODE_LSB +: 2]);
					s_d.cap_sel = wdata_in[CTRL_CAP_SEL];
				end
				OFS_PRESCALE: begin
					s_d.pr = wdata_in;
				end
				OFS_MATCH_CTRL: begin
					s_d.mcr = wdata_in[MCR_W-1:0];
				end
				OFS_OUT_CTRL: begin
					s_d.dbl = wdata_in[OCTL_DBL_LSB +: NUM_OUT];
					s_d.oen = wdata_in[OCTL_OEN_LSB +: NUM_OUT];
				end
				OFS_RELEASE: begin
					s_d.ler = s_d.ler | wdata_in[NUM_MATCH-1:0];
				end
				OFS_IRQ_EN: begin
					s_d.ien = wdata_in[NUM_MATCH-1:0];
				end
				default: begin
					if (wslot != NO_SLOT) begin
						s_d.shadow[wslot[2:0]] = wdata_in;
						// without pwm mode a write takes effect at once
						if (!s_q.pwm_en) begin
							s_d.act[wslot[2:0]] = wdata_in;
						end
					end
				end
			endcase
		end
		// sticky status: a new match beats a clear in the same cycle
		s_d.ir  = (s_q.ir & ~clr_mask) | int_req;
		s_d.irq = |(s_d.ir & s_d.ien);
		// read data for the next cycle
		if (rd_in) begin
			case (addr_in)
				OFS_CTRL: begin
					s_d.rdata[CTRL_CNT_EN]            = s_q.cnt_en;
					s_d.rdata[CTRL_CNT_RST]           = s_q.cnt_rst;
					s_d.rdata[CTRL_PWM_EN]            = s_q.pwm_en;
					s_d.rdata[CTRL_MODE_LSB +: 2]     = s_q.mode;
					s_d.rdata[CTRL_CAP_SEL]           = s_q.cap_sel;
				end
				OFS_COUNT:      s_d.rdata = s_q.tc;
				OFS_PRESCALE:   s_d.rdata = s_q.pr;
				OFS_PRECOUNT:   s_d.rdata = s_q.pc;
				OFS_MATCH_CTRL: s_d.rdata[MCR_W-1:0] = s_q.mcr;
				OFS_OUT_CTRL: begin
					s_d.rdata[OCTL_DBL_LSB +: NUM_OUT] = s_q.dbl;
					s_d.rdata[OCTL_OEN_LSB +: NUM_OUT] = s_q.oen;
				end
				OFS_RELEASE:    s_d.rdata[NUM_MATCH-1:0] = s_q.ler;
				OFS_IRQ_STAT:   s_d.rdata[NUM_MATCH-1:0] = s_q.ir;
				OFS_IRQ_EN:     s_d.rdata[NUM_MATCH-1:0] = s_q.ien;
				default: begin
					if (rslot != NO_SLOT) begin
						s_d.rdata = s_q.shadow[rslot[2:0]];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// edge placement for all pulse outputs
	mbpwm_outs u_outs (
		.clk_sys_in   (clk_sys_in),
		.rst_in       (rst_in),
		.pwm_en_in    (s_q.pwm_en),
		.oen_in       (s_q.oen),
		.dbl_in       (s_q.dbl),
		.fall_zero_in (fall_zero),
		.hit_in       (hit),
		.pwm_out      (pwm_out)
	);

	assign rdata_out = s_q.rdata;
	assign irq_out   = s_q.irq;

	// checks on counter, update and interrupt behaviour
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_period_tick;
		tick && s_q.pwm_en && hit[0];
	endsequence

	sequence s_plain_step;
		tick && !hit_rst && !s_q.cnt_rst;
	endsequence

	chk_period_reset: assert property (
		s_period_tick ##0 !(wr_in && addr_in == OFS_CTRL) |=> s_q.tc == RST_WORD)
		else $error("period match did not restart the count");
	chk_count_step: assert property (
		s_plain_step ##0 !(wr_in && addr_in == OFS_CTRL) |=> s_q.tc == $past(s_q.tc) + 32'h1)
		else $error("counter did not advance by one");
	chk_prescale_wrap: assert property (
		wrap ##0 !(wr_in && addr_in == OFS_CTRL) |=> s_q.pc == RST_WORD ##1 1'b1)
		else $error("prescaler did not wrap");
	chk_release_load: assert property (
		s_period_tick ##0 s_q.ler[1] ##0 !(wr_in && addr_in == OFS_RELEASE)
			|=> s_q.act[1] == $past(s_q.shadow[1]) && !s_q.ler[1])
		else $error("released value not loaded at period start");
	chk_update_hold: assert property (
		s_q.pwm_en && !xfer |=> $stable(s_q.act[2]))
		else $error("active match changed mid cycle");
	chk_unreleased_keep: assert property (
		xfer && !s_q.ler[3] |=> $stable(s_q.act[3]))
		else $error("unreleased match value took effect");
	chk_stop_match: assert property (
		tick && hit_stop && !wr_in |=> !s_q.cnt_en)
		else $error("stop on match did not halt the counter");
	chk_match_flag: assert property (
		hit[0] && s_q.mcr[MCR_INT] |=> s_q.ir[0] ##1 (s_q.ir[0] || $past(clr_mask[0])))
		else $error("match interrupt flag not raised");
	chk_irq_level: assert property (
		irq_out == |(s_q.ir & s_q.ien))
		else $error("interrupt output disagrees with status");
	chk_timer_quiet: assert property (
		!s_q.pwm_en |=> pwm_out == '0)
		else $error("pulse output active outside pwm mode");

endmodule

`default_nettype wire

//--- hdl/mbpwm_pkg.sv
`default_nettype none

package mbpwm_pkg;

	// sizes of the unit
	localparam int unsigned NUM_MATCH = 7;
	localparam int unsigned NUM_OUT   = 6;
	localparam int unsigned NUM_CAP   = 2;
	localparam int unsigned DATA_W    = 32;
	localparam int unsigned ADDR_W    = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_COUNT      = 8'h04;
	localparam logic [7:0] OFS_PRESCALE   = 8'h08;
	localparam logic [7:0] OFS_PRECOUNT   = 8'h0C;
	localparam logic [7:0] OFS_MATCH_CTRL = 8'h10;
	localparam logic [7:0] OFS_OUT_CTRL   = 8'h14;
	localparam logic [7:0] OFS_RELEASE    = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h1C;
	localparam logic [7:0] OFS_IRQ_CLR    = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h24;
	localparam logic [7:0] OFS_MATCH_BASE = 8'h28;

	// control register fields
	localparam int unsigned CTRL_CNT_EN   = 0;
	localparam int unsigned CTRL_CNT_RST  = 1;
	localparam int unsigned CTRL_PWM_EN   = 2;
	localparam int unsigned CTRL_MODE_LSB = 3;
	localparam int unsigned CTRL_CAP_SEL  = 5;

	// match control: three bits per match register
	localparam int unsigned MCR_INT    = 0;
	localparam int unsigned MCR_RST    = 1;
	localparam int unsigned MCR_STOP   = 2;
	localparam int unsigned MCR_STRIDE = 3;
	localparam int unsigned MCR_W      = 21;

	// output control fields
	localparam int unsigned OCTL_DBL_LSB = 0;
	localparam int unsigned OCTL_OEN_LSB = 8;

	// reset values
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [3:0]  NO_SLOT   = 4'hF;

	// count clock source
	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_RISE  = 2'b01,
		MODE_FALL  = 2'b10,
		MODE_BOTH  = 2'b11
	} mbpwm_mode_e;

endpackage

`default_nettype wire

//--- hdl/mbpwm_sync.sv
`timescale 1ns/10ps
`default_nettype none

module mbpwm_sync (
	// clock and reset
	input  wire logic                          clk_sys_in,
	input  wire logic                          rst_in,
	// raw pins and filtered levels
	input  wire logic [mbpwm_pkg::NUM_CAP-1:0] pin_in,
	output logic      [mbpwm_pkg::NUM_CAP-1:0] lvl_out
);
	import mbpwm_pkg::*;

	typedef struct packed {
		logic [NUM_CAP-1:0] s1;
		logic [NUM_CAP-1:0] s2;
		logic [NUM_CAP-1:0] s3;
		logic [NUM_CAP-1:0] lvl;
	} mbpwm_sync_s;

	mbpwm_sync_s s_q;
	mbpwm_sync_s s_d;

	// three stages; level moves once stages two and three agree
	always_comb begin
		s_d     = s_q;
		s_d.s1  = pin_in;
		s_d.s2  = s_q.s1;
		s_d.s3  = s_q.s2;
		s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 | s_q.s3));
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lvl_out = s_q.lvl;

endmodule

`default_nettype wire

//--- hdl/mbpwm_outs.sv
`timescale 1ns/10ps
`default_nettype none

module mbpwm_outs (
	// clock and reset
	input  wire logic                            clk_sys_in,
	input  wire logic                            rst_in,
	// configuration
	input  wire logic                            pwm_en_in,
	input  wire logic [mbpwm_pkg::NUM_OUT-1:0]   oen_in,
	input  wire logic [mbpwm_pkg::NUM_OUT-1:0]   dbl_in,
	input  wire logic [mbpwm_pkg::NUM_OUT-1:0]   fall_zero_in,
	// match pulses
	input  wire logic [mbpwm_pkg::NUM_MATCH-1:0] hit_in,
	// pulse outputs
	output logic      [mbpwm_pkg::NUM_OUT-1:0]   pwm_out
);
	import mbpwm_pkg::*;

	typedef struct packed {
		logic [NUM_OUT-1:0] lvl;
	} mbpwm_outs_s;

	mbpwm_outs_s        s_q;
	mbpwm_outs_s        s_d;
	logic [NUM_OUT-1:0] set_ev;
	logic [NUM_OUT-1:0] clr_ev;

	// output n rises on period match or on match n-1, falls on match n
	for (genvar j = 0; j < NUM_OUT; j++) begin : g_edge
		if (j == 0) begin : g_single
			assign set_ev[j] = hit_in[0] & ~fall_zero_in[j];
		end else begin : g_mixed
			assign set_ev[j] = dbl_in[j] ? hit_in[j] : (hit_in[0] & ~fall_zero_in[j]);
		end
		assign clr_ev[j] = hit_in[j+1];
	end

	// fall wins a tie; disabled outputs stay low
	always_comb begin
		s_d     = s_q;
		s_d.lvl = ((s_q.lvl | set_ev) & ~clr_ev) & oen_in & {NUM_OUT{pwm_en_in}};
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pwm_out = s_q.lvl;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	chk_single_rise: assert property (
		pwm_en_in && oen_in[0] && hit_in[0] && !fall_zero_in[0] && !hit_in[1] |=> pwm_out[0])
		else $error("single edge output missed its rise");
	chk_const_low: assert property (
		pwm_en_in && oen_in[5] && !dbl_in[5] && fall_zero_in[5] && !pwm_out[5] |=> !pwm_out[5])
		else $error("constant low output went high");
	chk_double_rise: assert property (
		pwm_en_in && oen_in[1] && dbl_in[1] && hit_in[1] && !hit_in[2] |=> pwm_out[1])
		else $error("double edge output missed its rise");
	chk_double_fall: assert property (
		dbl_in[1] && hit_in[2] |=> !pwm_out[1])
		else $error("double edge output missed its fall");

endmodule

`default_nettype wire

//--- test/mbpwm_load.sv
`timescale 1ns/10ps
`default_nettype none

module mbpwm_load (
	// clock and meter clear
	input  wire logic                                 clk_sys_in,
	input  wire logic                                 clr_in,
	// pulse outputs as seen at the loads
	input  wire logic [mbpwm_pkg::NUM_OUT-1:0]        pwm_in,
	// high time and pulse count of each load
	output logic      [mbpwm_pkg::NUM_OUT-1:0][15:0]  hi_cnt_out,
	output logic      [mbpwm_pkg::NUM_OUT-1:0][7:0]   rise_cnt_out
);
	import mbpwm_pkg::*;
	logic [NUM_OUT-1:0] last_q;

	// each load integrates its high time and counts its pulses
	always_ff @(posedge clk_sys_in) begin
		last_q <= pwm_in;
		for (int j = 0; j < NUM_OUT; j++) begin
			if (clr_in) begin
				hi_cnt_out[j]   <= 16'h0000;
				rise_cnt_out[j] <= 8'h00;
			end else begin
				hi_cnt_out[j]   <= hi_cnt_out[j] + 16'(pwm_in[j]);
				rise_cnt_out[j] <= rise_cnt_out[j] + 8'(pwm_in[j] & ~last_q[j]);
			end
		end
	end
endmodule

`default_nettype wire

//--- test/match_based_pwm_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none

module match_based_pwm_unit_tb;
	import mbpwm_pkg::*;
	typedef struct {
		logic [31:0] pre;
		logic [7:0]  m [7];
		logic [5:0]  dbl;
		logic [5:0]  oen;
	} mbpwm_row_s;

	logic              clk_sys_in = 1'b0;
	logic              rst_in     = 1'b1;
	logic [7:0]        addr_in    = 8'h00;
	logic [31:0]       wdata_in   = 32'h0;
	logic              wr_in      = 1'b0;
	logic              rd_in      = 1'b0;
	logic [1:0]        capture_in = 2'h0;
	logic              clr_q      = 1'b0;
	logic [31:0]       rdata_out;
	logic [5:0]        pwm_out;
	logic              irq_out;
	logic [5:0][15:0]  hi_w;
	logic [5:0][7:0]   rise_w;
	logic [31:0]       rd_q;
	int                fail_count = 0;
	int                check_count = 0;
	int                per;
	// single, mixed double, partly disabled
	mbpwm_row_s rows [3] = '{
		'{32'h0, '{8'h09, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00}, 6'h00, 6'h3F},
		'{32'h2, '{8'h0B, 8'h02, 8'h07, 8'h09, 8'h03, 8'h04, 8'h08}, 6'h2A, 6'h3F},
		'{32'h1, '{8'h04, 8'h01, 8'h02, 8'h03, 8'h03, 8'h01, 8'h02}, 6'h00, 6'h15}};

	// 250 MHz system clock
	always #2 clk_sys_in = ~clk_sys_in;

	mbpwm_top u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.capture_in(capture_in), .pwm_out(pwm_out), .irq_out(irq_out));

	mbpwm_load u_load (.clk_sys_in(clk_sys_in), .clr_in(clr_q), .pwm_in(pwm_out),
		.hi_cnt_out(hi_w), .rise_cnt_out(rise_w));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 rd_q = rdata_out;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_q, exp);
	endtask

	// expected high clocks per cycle of output n
	function automatic int hw(mbpwm_row_s r, int n);
		int s;
		s = int'(r.pre) + 1;
		if (!r.oen[n-1])
			return 0;
		if (n > 1 && r.dbl[n-1]) begin
			if (r.m[n-1] < r.m[n])
				return (r.m[n] - r.m[n-1]) * s;
			return (r.m[0] + 1 - (r.m[n-1] - r.m[n])) * s;
		end
		// high from the period tick through the tick of its own match; zero holds it low
		return (r.m[n] == 8'h00) ? 0 : (r.m[n] + 1) * s;
	endfunction

	// settle, then meter the loads over four whole cycles
	task automatic measure(mbpwm_row_s r, int p);
		int w;
		repeat (2 * p) @(posedge clk_sys_in);
		clr_q <= 1'b1;
		@(posedge clk_sys_in);
		clr_q <= 1'b0;
		repeat (4 * p) @(posedge clk_sys_in);
		#1;
		for (int n = 1; n <= 6; n++) begin
			w = hw(r, n);
			chk({16'h0, hi_w[n-1]}, 32'(4 * w));
			chk({24'h0, rise_w[n-1]}, (w > 0 && w < p) ? 32'h4 : 32'h0);
		end
	endtask

	task automatic results;
		$display("checks=%0d errors=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (30000) @(posedge clk_sys_in);
		fail_count++;
		results();
	end

	// main sequence
	initial begin
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CTRL, 32'h2);
			wr(OFS_PRESCALE, rows[i].pre);
			for (int k = 0; k < 7; k++)
				wr(OFS_MATCH_BASE + 8'(4 * k), 32'(rows[i].m[k]));
			wr(OFS_OUT_CTRL, {18'h0, rows[i].oen, 2'h0, rows[i].dbl});
			wr(OFS_CTRL, 32'h5);
			per = (rows[i].m[0] + 1) * (int'(rows[i].pre) + 1);
			measure(rows[i], per);
		end
		// unreleased value is held back, released one lands at cycle start
		wr(OFS_MATCH_BASE + 8'h04, 32'h3);
		rdc(OFS_MATCH_BASE + 8'h04, 32'h3);
		measure(rows[2], 10);
		rows[2].m[1] = 8'h03;
		wr(OFS_RELEASE, 32'h2);
		measure(rows[2], 10);
		rdc(OFS_RELEASE, 32'h0);
		// timer mode: interrupt on matches 0 and 2, interrupt and stop on match 3
		wr(OFS_CTRL, 32'h2);
		wr(OFS_PRESCALE, 32'h0);
		wr(OFS_MATCH_BASE + 8'h08, 32'h4);
		wr(OFS_MATCH_BASE + 8'h0C, 32'h7);
		wr(OFS_MATCH_CTRL, 32'h0000_0A41);
		wr(OFS_CTRL, 32'h1);
		repeat (20) @(posedge clk_sys_in);
		rdc(OFS_IRQ_STAT, 32'hD);
		chk({31'h0, irq_out}, 32'h0);
		rdc(OFS_CTRL, 32'h0);
		// the stopping tick still steps the count once, then it holds
		rdc(OFS_COUNT, 32'h8);
		rdc(OFS_COUNT, 32'h8);
		chk({26'h0, pwm_out}, 32'h0);
		wr(OFS_IRQ_EN, 32'h8);
		repeat (2) @(posedge clk_sys_in);
		#1 chk({31'h0, irq_out}, 32'h1);
		wr(OFS_IRQ_CLR, 32'h8);
		repeat (2) @(posedge clk_sys_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		rdc(OFS_IRQ_STAT, 32'h5);
		// reset on match 2 keeps the count within 0..4
		wr(OFS_MATCH_CTRL, 32'h80);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h1);
		for (int k = 0; k < 6; k++) begin
			rd(OFS_COUNT);
			chk({31'h0, rd_q < 32'h5}, 32'h1);
		end
		// counter mode on rising edges of capture pin 0, pin 1 ignored
		wr(OFS_CTRL, 32'h2);
		wr(OFS_PRESCALE, 32'h1);
		wr(OFS_MATCH_CTRL, 32'h0);
		wr(OFS_CTRL, 32'h9);
		for (int k = 0; k < 20; k++) begin
			@(posedge clk_sys_in);
			capture_in <= (k % 2) ? 2'h0 : ((k % 4) ? 2'h2 : 2'h1);
			repeat (8) @(posedge clk_sys_in);
		end
		rdc(OFS_COUNT, 32'h2);
		rdc(OFS_PRECOUNT, 32'h1);
		// both edges of capture pin 1, then falling edges of pin 0
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h39);
		for (int k = 0; k < 6; k++) begin
			@(posedge clk_sys_in);
			capture_in <= (k % 2) ? 2'h0 : 2'h2;
			repeat (8) @(posedge clk_sys_in);
		end
		rdc(OFS_COUNT, 32'h3);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_CTRL, 32'h11);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys_in);
			capture_in <= (k % 2) ? 2'h0 : 2'h1;
			repeat (8) @(posedge clk_sys_in);
		end
		rdc(OFS_COUNT, 32'h1);
		// reset in mid-run clears outputs and registers
		wr(OFS_CTRL, 32'h5);
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1 chk({25'h0, irq_out, pwm_out}, 32'h0);
		wr(OFS_COUNT, 32'h55);
		wr(8'h80, 32'hFFFF_FFFF);
		for (int a = 0; a < 18; a++)
			rdc(8'(4 * a), 32'h0);
		rdc(8'h80, 32'h0);
		results();
	end
endmodule

`default_nettype wire
